//--- citm_consts.svh
// Constants for the core input tracking mux and its shadow-core end.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
// Functional notes
// - Instruction-register bits carry execute, decode handshakes.
// - Scan-select and TAP-state outputs carry interrupts, aborts, events.
// - Boundary-scan clock outputs carry control and test inputs.
// - Shadow fed from coprocessor buses, endian output.
// - Tracking mode mirrors data bus every cycle.
// - Coprocessor may stay attached during tracking.
// - Sync and test reset shared by both cores.
// - Shadow address bus enables held high.
// - Shadow data-bus drive enable held low.
// - Shadow needs no data drive; data-out supplies it.
// - Test clock sampled falling; others rising edge.
// - Shadow runs one phase behind, inverted clock.
// - Core-side inputs synchronous to core clock; test-port pins synchronised.
`ifndef CITM_CONSTS_SVH
`define CITM_CONSTS_SVH
`define CITM_DATA_W 32
`define CITM_IRB_W 4
`define CITM_SSEL_W 5
`define CITM_TSTATE_W 4
`define CITM_IRB_EXEC_HI 3
`define CITM_IRB_EXEC_LO 2
`define CITM_IRB_DEC_HI 1
`define CITM_IRB_DEC_LO 0
`define CITM_SSEL_IRQ 4
`define CITM_SSEL_FIQ 3
`define CITM_SSEL_DABT 2
`define CITM_SSEL_IABT 1
`define CITM_TSTATE_EXT1 3
`define CITM_TSTATE_EXT0 2
`define CITM_TSTATE_DWPT 1
`define CITM_TSTATE_IBKPT 0
`define CITM_RST_DATA 32'h0000_0000
`endif

//--- citm_device.sv
// Embedded core's output mux: normal test outputs, or tracking copies of core inputs.
// Assumes core-side inputs are on sys_clk; test-port pins are synchronised here.
`include "citm_consts.svh"
module citm_device (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Mode
  input wire logic tracking_mode,
  // Embedded core inputs to be tracked
  input wire citm_pkg::citm_hs_t cop_execute_handshake,
  input wire citm_pkg::citm_hs_t cop_decode_handshake,
  input wire logic irq_req_n,
  input wire logic fast_irq_req_n,
  input wire logic data_abort_in,
  input wire logic instr_abort_in,
  input wire logic ext_event_1,
  input wire logic ext_event_0,
  input wire logic data_watchpoint_in,
  input wire logic instr_breakpoint_in,
  input wire logic high_vector_select,
  input wire logic external_debug_request,
  input wire logic wait_n,
  input wire logic core_reset_n,
  input wire logic endian_select_in,
  // Test port pins
  input wire logic test_clock_pin,
  input wire logic test_data_in_pin,
  input wire logic test_mode_select_pin,
  input wire logic bscan_serial_out,
  // Coprocessor side
  input wire citm_pkg::citm_word_t cop_instr_id_in,
  input wire citm_pkg::citm_word_t data_bus,
  input wire logic cop_data_xfer,
  // Normal function sources
  input wire logic [`CITM_IRB_W-1:0] norm_instr_reg_bits,
  input wire logic [`CITM_SSEL_W-1:0] norm_scan_select,
  input wire logic [`CITM_TSTATE_W-1:0] norm_tap_state,
  input wire logic [5:0] norm_bscan_clks,
  input wire logic [1:0] norm_test_clocks,
  input wire logic norm_scan_serial_in,
  // Tracking link
  citm_if.device link
);
  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  logic [2:0] pin_s;
  logic tck_fall_reg;
  logic core_clk_phase_reg;

  // TDI, TMS and scan serial-out are taken on the rising edge.
  citm_sync2 #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({test_data_in_pin, test_mode_select_pin, bscan_serial_out}),
    .q(pin_s)
  );

  // The test clock is taken on the falling edge, after a rising-edge first stage.
  logic tck_meta_reg;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      tck_meta_reg <= 1'b0;
    else
      tck_meta_reg <= test_clock_pin;
  end

  always_ff @(negedge sys_clk)
  begin
    if (rst)
      tck_fall_reg <= 1'b0;
    else
      tck_fall_reg <= tck_meta_reg;
  end

  // Core clock copy as a toggling level, one per cycle.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      core_clk_phase_reg <= 1'b0;
    else
      core_clk_phase_reg <= ~core_clk_phase_reg;
  end

  // ----------------------------------------------------------------
  // Output mux registers
  // ----------------------------------------------------------------
  // Instruction-register bits carry the coprocessor handshakes while tracking.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      link.instr_reg_bits_out <= '0;
    else if (tracking_mode)
    begin
      link.instr_reg_bits_out[`CITM_IRB_EXEC_HI:`CITM_IRB_EXEC_LO] <=
        cop_execute_handshake;
      link.instr_reg_bits_out[`CITM_IRB_DEC_HI:`CITM_IRB_DEC_LO] <=
        cop_decode_handshake;
    end
    else
      link.instr_reg_bits_out <= norm_instr_reg_bits;
  end

  // Scan-select bits carry interrupts and aborts; bit 0 keeps its normal use.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      link.scan_select_out <= '0;
    else if (tracking_mode)
    begin
      link.scan_select_out[`CITM_SSEL_IRQ] <= irq_req_n;
      link.scan_select_out[`CITM_SSEL_FIQ] <= fast_irq_req_n;
      link.scan_select_out[`CITM_SSEL_DABT] <= data_abort_in;
      link.scan_select_out[`CITM_SSEL_IABT] <= instr_abort_in;
      link.scan_select_out[0] <= norm_scan_select[0];
    end
    else
      link.scan_select_out <= norm_scan_select;
  end

  // Tap-state bits carry the external events, watchpoint and breakpoint.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      link.tap_state_out <= '0;
    else if (tracking_mode)
    begin
      link.tap_state_out[`CITM_TSTATE_EXT1] <= ext_event_1;
      link.tap_state_out[`CITM_TSTATE_EXT0] <= ext_event_0;
      link.tap_state_out[`CITM_TSTATE_DWPT] <= data_watchpoint_in;
      link.tap_state_out[`CITM_TSTATE_IBKPT] <= instr_breakpoint_in;
    end
    else
      link.tap_state_out <= norm_tap_state;
  end

  // Boundary-scan clock pins carry core control inputs and the test port inputs.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      link.bscan_int_capture_clk <= 1'b0;
      link.bscan_ext_capture_clk <= 1'b0;
      link.bscan_update_clk <= 1'b0;
      link.bscan_reset_clk <= 1'b0;
      link.bscan_shift_clk_a <= 1'b0;
      link.bscan_shift_clk_b <= 1'b0;
    end
    else if (tracking_mode)
    begin
      link.bscan_int_capture_clk <= high_vector_select;
      link.bscan_ext_capture_clk <= external_debug_request;
      link.bscan_update_clk <= wait_n;
      link.bscan_reset_clk <= core_reset_n;
      link.bscan_shift_clk_a <= pin_s[2];
      link.bscan_shift_clk_b <= pin_s[1];
    end
    else
    begin
      link.bscan_int_capture_clk <= norm_bscan_clks[5];
      link.bscan_ext_capture_clk <= norm_bscan_clks[4];
      link.bscan_update_clk <= norm_bscan_clks[3];
      link.bscan_reset_clk <= norm_bscan_clks[2];
      link.bscan_shift_clk_a <= norm_bscan_clks[1];
      link.bscan_shift_clk_b <= norm_bscan_clks[0];
    end
  end

  // Test clock pins carry the core clock copy and the sampled test clock.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      link.test_clock_out_a <= 1'b0;
      link.test_clock_out_b <= 1'b0;
      link.scan_serial_in_out <= 1'b0;
    end
    else if (tracking_mode)
    begin
      link.test_clock_out_a <= core_clk_phase_reg;
      link.test_clock_out_b <= tck_fall_reg;
      link.scan_serial_in_out <= pin_s[0];
    end
    else
    begin
      link.test_clock_out_a <= norm_test_clocks[1];
      link.test_clock_out_b <= norm_test_clocks[0];
      link.scan_serial_in_out <= norm_scan_serial_in;
    end
  end

  // ----------------------------------------------------------------
  // Coprocessor buses
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      link.cop_instr_id_bus <= `CITM_RST_DATA;
      link.cop_data_out_bus <= `CITM_RST_DATA;
      link.endian_select_out <= 1'b0;
    end
    else
    begin
      link.cop_instr_id_bus <= cop_instr_id_in;
      link.endian_select_out <= endian_select_in;
      if (tracking_mode || cop_data_xfer)
        link.cop_data_out_bus <= data_bus;
    end
  end
endmodule // citm_device

//--- citm_if.sv
// Tracking link between the embedded core's output mux and the shadow core end.
// Assumes both ends run on sys_clk.
`include "citm_consts.svh"
interface citm_if;
  logic [`CITM_IRB_W-1:0] instr_reg_bits_out;
  logic [`CITM_SSEL_W-1:0] scan_select_out;
  logic [`CITM_TSTATE_W-1:0] tap_state_out;
  logic bscan_int_capture_clk;
  logic bscan_ext_capture_clk;
  logic bscan_update_clk;
  logic bscan_reset_clk;
  logic bscan_shift_clk_a;
  logic bscan_shift_clk_b;
  logic test_clock_out_a;
  logic test_clock_out_b;
  logic scan_serial_in_out;
  citm_pkg::citm_word_t cop_instr_id_bus;
  citm_pkg::citm_word_t cop_data_out_bus;
  logic endian_select_out;
  modport device (
    output instr_reg_bits_out, scan_select_out, tap_state_out,
    output bscan_int_capture_clk, bscan_ext_capture_clk, bscan_update_clk,
    output bscan_reset_clk, bscan_shift_clk_a, bscan_shift_clk_b,
    output test_clock_out_a, test_clock_out_b, scan_serial_in_out,
    output cop_instr_id_bus, cop_data_out_bus, endian_select_out
  );
  modport shadow (
    input instr_reg_bits_out, scan_select_out, tap_state_out,
    input bscan_int_capture_clk, bscan_ext_capture_clk, bscan_update_clk,
    input bscan_reset_clk, bscan_shift_clk_a, bscan_shift_clk_b,
    input test_clock_out_a, test_clock_out_b, scan_serial_in_out,
    input cop_instr_id_bus, cop_data_out_bus, endian_select_out
  );
endinterface

//--- citm_link_properties.sv
// Concurrent checks on the tracking link between the device mux and the shadow end.
// Assumes one clock, a synchronous active-high reset and registered link outputs.
`include "citm_consts.svh"
module citm_link_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Device inputs
  input wire logic tracking_mode,
  input wire citm_pkg::citm_hs_t cop_execute_handshake,
  input wire citm_pkg::citm_hs_t cop_decode_handshake,
  input wire logic irq_req_n,
  input wire logic wait_n,
  input wire logic test_data_in_pin,
  input wire logic cop_data_xfer,
  input wire citm_pkg::citm_word_t data_bus,
  input wire logic [`CITM_SSEL_W-1:0] norm_scan_select,
  // Link signals
  input wire logic [`CITM_IRB_W-1:0] instr_reg_bits_out,
  input wire logic [`CITM_SSEL_W-1:0] scan_select_out,
  input wire logic bscan_update_clk,
  input wire logic bscan_shift_clk_a,
  input wire logic test_clock_out_a,
  input wire citm_pkg::citm_word_t cop_data_out_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  // Counts consecutive tracking cycles out of reset, saturating at three.
  logic [1:0] trk_reg;
  always_ff @(posedge sys_clk)
  begin
    if (rst || !tracking_mode)
      trk_reg <= 2'h0;
    else if (trk_reg != 2'h3)
      trk_reg <= trk_reg + 2'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_hs;
    trk_reg != 2'h0 |-> instr_reg_bits_out == $past({cop_execute_handshake, cop_decode_handshake});
  endproperty
  a_hs: assert property (p_hs) else $error("handshake copy wrong");
  property p_irq;
    trk_reg != 2'h0 |-> scan_select_out[4] == $past(irq_req_n);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt copy wrong");
  property p_ctl;
    trk_reg != 2'h0 |-> bscan_update_clk == $past(wait_n);
  endproperty
  a_ctl: assert property (p_ctl) else $error("wait copy wrong");
  property p_tdi;
    trk_reg == 2'h3 |-> bscan_shift_clk_a == $past(test_data_in_pin, 3);
  endproperty
  a_tdi: assert property (p_tdi) else $error("test data copy wrong");
  property p_clk;
    trk_reg >= 2'h2 |-> test_clock_out_a != $past(test_clock_out_a);
  endproperty
  a_clk: assert property (p_clk) else $error("core clock copy stuck");
  property p_mir;
    trk_reg != 2'h0 |-> cop_data_out_bus == $past(data_bus);
  endproperty
  a_mir: assert property (p_mir) else $error("data mirror wrong");
  property p_norm;
    !$past(rst) && !$past(tracking_mode) |-> scan_select_out == $past(norm_scan_select);
  endproperty
  a_norm: assert property (p_norm) else $error("normal select wrong");
  property p_hold;
    !$past(rst) && !$past(tracking_mode) && !$past(cop_data_xfer) |-> $stable(cop_data_out_bus);
  endproperty
  a_hold: assert property (p_hold) else $error("data out not held");
endmodule // citm_link_properties

//--- citm_pkg.sv
// Types shared by both ends of the tracking link.
// Assumes citm_consts.svh is on the include path.
`include "citm_consts.svh"
package citm_pkg;
  typedef logic [`CITM_DATA_W-1:0] citm_word_t;
  typedef logic [1:0] citm_hs_t;
endpackage

//--- citm_shadow.sv
// Shadow core input end: turns the tracking link back into core input signals.
// Assumes the shadow core itself samples these on the inverted clock.
`include "citm_consts.svh"
module citm_shadow (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Shared environment inputs
  input wire logic instr_sync_in,
  input wire logic test_reset_n_in,
  // Tracking link
  citm_if.shadow link,
  // Shadow core inputs
  output citm_pkg::citm_hs_t cop_execute_handshake,
  output citm_pkg::citm_hs_t cop_decode_handshake,
  output logic [3:0] core_int_abort,
  output logic [3:0] core_events,
  output logic [5:0] core_ctrl,
  output logic [1:0] core_clocks,
  output logic scan_serial_in,
  output citm_pkg::citm_word_t instr_data_bus,
  output citm_pkg::citm_word_t data_bus,
  output logic endian_select_in,
  output logic instr_sync,
  output logic test_reset_n,
  output logic instr_addr_bus_enable,
  output logic data_addr_bus_enable,
  output logic data_bus_drive_enable
);
  // Captured on the falling edge so the shadow trails by one phase.
  always_ff @(negedge sys_clk)
  begin
    if (rst)
    begin
      cop_execute_handshake <= '0;
      cop_decode_handshake <= '0;
      core_int_abort <= '0;
      core_events <= '0;
      core_ctrl <= '0;
      core_clocks <= '0;
      scan_serial_in <= 1'b0;
      instr_data_bus <= `CITM_RST_DATA;
      data_bus <= `CITM_RST_DATA;
      endian_select_in <= 1'b0;
      instr_sync <= 1'b0;
      test_reset_n <= 1'b0;
    end
    else
    begin
      cop_execute_handshake <= link.instr_reg_bits_out[`CITM_IRB_EXEC_HI:`CITM_IRB_EXEC_LO];
      cop_decode_handshake <= link.instr_reg_bits_out[`CITM_IRB_DEC_HI:`CITM_IRB_DEC_LO];
      core_int_abort <= link.scan_select_out[`CITM_SSEL_IRQ:`CITM_SSEL_IABT];
      core_events <= link.tap_state_out;
      core_ctrl <= {link.bscan_int_capture_clk, link.bscan_ext_capture_clk,
        link.bscan_update_clk, link.bscan_reset_clk, link.bscan_shift_clk_a,
        link.bscan_shift_clk_b};
      core_clocks <= {link.test_clock_out_a, link.test_clock_out_b};
      scan_serial_in <= link.scan_serial_in_out;
      instr_data_bus <= link.cop_instr_id_bus;
      data_bus <= link.cop_data_out_bus;
      endian_select_in <= link.endian_select_out;
      instr_sync <= instr_sync_in;
      test_reset_n <= test_reset_n_in;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      instr_addr_bus_enable <= 1'b1;
      data_addr_bus_enable <= 1'b1;
      data_bus_drive_enable <= 1'b0;
    end
    else
    begin
      instr_addr_bus_enable <= 1'b1;
      data_addr_bus_enable <= 1'b1;
      data_bus_drive_enable <= 1'b0;
    end
  end
endmodule // citm_shadow

//--- citm_sync2.sv
// Two-flop synchroniser for inputs arriving from pins.
// Assumes a single clock; width is a parameter.
module citm_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // citm_sync2

//--- test_core_input_tracking_mux.sv
// Random bench joining the device mux to the shadow end over the tracking link.
// Assumes the design files are compiled first.
`include "citm_consts.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", n, e, a); end end
module test_core_input_tracking_mux;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic tm = 1'b1;
  logic rp, tp;
  logic [45:0] s = '0;
  logic [45:0] sp, sp1, sp2;
  int since = 0;
  citm_pkg::citm_word_t dw = '0;
  citm_pkg::citm_word_t iw = '0;
  citm_pkg::citm_word_t dp, ip;
  citm_pkg::citm_word_t cdo = '0;
  citm_pkg::citm_hs_t sh_e, sh_d;
  logic [3:0] sh_ia, sh_ev;
  logic [5:0] sh_ct;
  logic [1:0] sh_ck;
  citm_pkg::citm_word_t sh_ib, sh_db;
  logic sh_en, sh_sy, sh_tr, sh_iae, sh_dae, sh_dde, sh_si;
  logic [12:0] lk;
  logic [8:0] nc;
  int unsigned seed;
  int fails = 0;
  int num_checks = 0;
  citm_if link ();
  always #50 sys_clk = ~sys_clk;
  assign lk = {link.instr_reg_bits_out, link.scan_select_out, link.tap_state_out};
  assign nc = {link.scan_serial_in_out, link.test_clock_out_a, link.test_clock_out_b,
    link.bscan_int_capture_clk, link.bscan_ext_capture_clk, link.bscan_update_clk,
    link.bscan_reset_clk, link.bscan_shift_clk_a, link.bscan_shift_clk_b};
  citm_device u_citm_device (
    .sys_clk(sys_clk), .rst(rst), .tracking_mode(tm),
    .cop_execute_handshake(s[3:2]), .cop_decode_handshake(s[1:0]),
    .irq_req_n(s[7]), .fast_irq_req_n(s[6]), .data_abort_in(s[5]), .instr_abort_in(s[4]),
    .ext_event_1(s[11]), .ext_event_0(s[10]), .data_watchpoint_in(s[9]),
    .instr_breakpoint_in(s[8]), .high_vector_select(s[15]), .external_debug_request(s[14]),
    .wait_n(s[13]), .core_reset_n(s[12]), .endian_select_in(s[16]), .test_clock_pin(s[20]),
    .test_data_in_pin(s[19]), .test_mode_select_pin(s[18]), .bscan_serial_out(s[17]),
    .cop_instr_id_in(iw), .data_bus(dw), .cop_data_xfer(s[21]),
    .norm_instr_reg_bits(s[25:22]), .norm_scan_select(s[30:26]), .norm_tap_state(s[34:31]),
    .norm_bscan_clks(s[40:35]), .norm_test_clocks(s[42:41]), .norm_scan_serial_in(s[43]),
    .link(link.device));
  citm_shadow u_citm_shadow (
    .sys_clk(sys_clk), .rst(rst), .instr_sync_in(s[44]), .test_reset_n_in(s[45]),
    .link(link.shadow), .cop_execute_handshake(sh_e), .cop_decode_handshake(sh_d),
    .core_int_abort(sh_ia), .core_events(sh_ev), .core_ctrl(sh_ct), .core_clocks(sh_ck),
    .scan_serial_in(sh_si), .instr_data_bus(sh_ib), .data_bus(sh_db), .endian_select_in(sh_en),
    .instr_sync(sh_sy), .test_reset_n(sh_tr), .instr_addr_bus_enable(sh_iae),
    .data_addr_bus_enable(sh_dae), .data_bus_drive_enable(sh_dde));
  citm_link_properties u_props (
    .sys_clk(sys_clk), .rst(rst), .tracking_mode(tm), .cop_execute_handshake(s[3:2]),
    .cop_decode_handshake(s[1:0]), .irq_req_n(s[7]), .wait_n(s[13]), .test_data_in_pin(s[19]),
    .cop_data_xfer(s[21]), .data_bus(dw), .norm_scan_select(s[30:26]),
    .instr_reg_bits_out(link.instr_reg_bits_out), .scan_select_out(link.scan_select_out),
    .bscan_update_clk(link.bscan_update_clk), .bscan_shift_clk_a(link.bscan_shift_clk_a),
    .test_clock_out_a(link.test_clock_out_a), .cop_data_out_bus(link.cop_data_out_bus));
  function automatic logic [12:0] exp_lk(input logic [45:0] v, input logic t);
    return t ? {v[3:0], v[7:4], v[26], v[11:8]} : {v[25:22], v[30:26], v[34:31]};
  endfunction
  function automatic logic [15:0] exp_sh(input logic [45:0] v);
    return {v[3:0], v[7:4], v[11:8], v[15:12]};
  endfunction
  task automatic results();
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    seed = $urandom(32'h61b4e8e0);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge sys_clk);
      sp2 = sp1;
      sp1 = sp;
      sp = s;
      rp = rst;
      since = rp ? 0 : since + 1;
      tp = tm;
      dp = dw;
      ip = iw;
      s <= 46'({$urandom, $urandom});
      dw <= (i % 7 == 0) ? 32'hffff_ffff : $urandom;
      iw <= $urandom;
      tm <= (i % 50) < 35;
      rst <= (i == 200);
      #60;
      if (rp)
        cdo = '0;
      else if (tp || sp[21])
        cdo = dp;
      if (!rst)
      begin
        `CHK("link data out", cdo, link.cop_data_out_bus)
        `CHK("shadow sync", s[45:44], {sh_tr, sh_sy})
        `CHK("shadow enables", 3'b110, {sh_iae, sh_dae, sh_dde})
      end
      if (rp)
        `CHK("shadow after reset", 4'h0, sh_ia)
      if (!rst && !rp)
      begin
        `CHK("link handshake scan state", exp_lk(sp, tp), lk)
        if (tp)
        begin
          `CHK("shadow inputs", exp_sh(sp), {sh_e, sh_d, sh_ia, sh_ev, sh_ct[5:2]})
          `CHK("shadow buses", {ip, dp, sp[16]}, {sh_ib, sh_db, sh_en})
          if (since >= 3)
          begin
            `CHK("shadow clocks", {~since[0], sp1[20]}, sh_ck)
            `CHK("shadow test port", sp2[19:17], {sh_ct[1:0], sh_si})
          end
        end
        else
          `CHK("normal clocks", sp[43:35], nc)
      end
    end
    results();
  end
endmodule // test_core_input_tracking_mux
